// ---- drt_pkg.sv ----
// Purpose: Shared constants and types for the refresh/power-down link
// Assumes: Link clock derived from pclk, command timing counted in CK
// Notes:   Times in ns convert to CK counts by the expressions below
package drt_pkg;

	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	localparam int CLK_NS  = 10;
	localparam int CK_HALF = 4;
	localparam int CK_NS   = 2 * CK_HALF * CLK_NS;
	localparam int DIV_W   = 3;
	localparam int CW      = 8;

	// ----------------------------------------------------------------
	// Device geometry and latencies
	// ----------------------------------------------------------------
	localparam int AW      = 13;
	localparam int BW      = 2;
	localparam int NBANK   = 4;
	localparam int A10_BIT = 10;
	localparam int A12_BIT = 12;
	localparam int CL      = 3;
	localparam int AL      = 0;
	localparam int BL      = 4;
	localparam int BL2     = BL / 2;
	localparam int RL      = AL + CL;
	localparam int WL      = RL - 1;
	localparam int TWTR    = 2;
	localparam int WR      = 3;

	// ----------------------------------------------------------------
	// Timing in ns and in CK cycles
	// ----------------------------------------------------------------
	localparam int TRP_NS   = 15;
	localparam int TRCD_NS  = 15;
	localparam int TRFC_NS  = 75;
	localparam int TXSNR_NS = 85;
	localparam int TREFI_NS = 7800;
	localparam int TRP_CK   = (TRP_NS + CK_NS - 1) / CK_NS;
	localparam int TRCD_CK  = (TRCD_NS + CK_NS - 1) / CK_NS;
	localparam int TRFC_CK  = (TRFC_NS + CK_NS - 1) / CK_NS;
	localparam int TXSNR_CK = (TXSNR_NS + CK_NS - 1) / CK_NS;
	localparam int TREFI_CK = TREFI_NS / CK_NS;
	localparam int SREF_CYC = TREFI_NS / CLK_NS;
	localparam int TXSRD_CK  = 200;
	localparam int TXP_CK    = 2;
	localparam int TXARDS_CK = 6 - AL;
	localparam int TCKE_CK   = 3;
	localparam int TMRD_CK   = 2;
	localparam int MAX_POST  = 8;

	// Spacing after read/write, with or without auto-precharge
	localparam int RDA_RD = BL2;
	localparam int RDA_WR = BL2 + 2;
	localparam int RDA_PA = 1;
	localparam int RD_PD  = RL + BL2;
	localparam int WRA_RD = (CL - 1) + BL2 + TWTR;
	localparam int WRA_WR = BL2;
	localparam int WR_PD  = WL + BL2 + TWTR;
	localparam int WRA_PD = WL + BL2 + WR;

	// ----------------------------------------------------------------
	// Pin codes {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;

	// ----------------------------------------------------------------
	// Controller registers
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_AUTO  = 0;
	localparam int CTRL_ODT   = 1;
	localparam int CMDF_OP    = 0;
	localparam int CMDF_BANK  = 4;
	localparam int CMDF_AP    = 6;
	localparam int CMDF_ADDR  = 8;
	localparam int STF_PEND   = 0;
	localparam int STF_STATE  = 1;
	localparam int STF_OPEN   = 3;
	localparam int STF_NEED   = 7;
	localparam int STF_POST   = 8;
	localparam int STF_XSRD   = 12;

	typedef enum logic [3:0] {
		OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_PREA, OP_REF, OP_MRS,
		OP_SRE, OP_SRX, OP_PDE, OP_PDX
	} drt_op_type;

	typedef enum logic [1:0] {ST_RUN, ST_PD, ST_SR} drt_state_type;

endpackage

// ---- drt_link_if.sv ----
// Purpose: Command/CKE link between controller and memory device
// Assumes: Controller drives every signal, device only samples
// Notes:   No two-way pins on this link
`timescale 1ns/100ps
interface drt_link_if import drt_pkg::*; ();
	logic          ck;
	logic          cke;
	logic          cs_n;
	logic          ras_n;
	logic          cas_n;
	logic          we_n;
	logic          odt;
	logic [BW-1:0] ba;
	logic [AW-1:0] addr;

	modport ctl (output ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
	modport mem (input ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface

// ---- drt_mem.sv ----
// Purpose: Device end: decodes refresh, self-refresh and power-down
// Assumes: Link pins are asynchronous to pclk and synchronised here
// Notes:   Self-refresh timer runs on pclk since CK may stop
`timescale 1ns/100ps
module drt_mem import drt_pkg::*; (
	input  wire logic          pclk,        // System clock
	input  wire logic          presetn,     // Async reset, active low
	drt_link_if.mem            lk,          // Link from controller
	output logic [AW-1:0]      ref_row,     // Internal refresh row counter
	output logic               ref_pulse,   // One refresh performed
	output logic               sref_on,     // In self-refresh
	output logic               pd_on,       // In power-down
	output logic               pd_active,   // Power-down with row open
	output logic               dll_en,      // DLL running
	output logic               inbuf_en,    // Input/output buffers on
	output logic               burst_busy,  // Data burst running
	output logic [NBANK-1:0]   open_banks   // Rows open per bank
);

	typedef struct packed {
		logic          ck;
		logic          cke;
		logic [3:0]    cmd;
		logic          odt;
		logic [BW-1:0] ba;
		logic [AW-1:0] addr;
	} drt_pin_type;

	typedef struct packed {
		drt_pin_type      s1;
		drt_pin_type      s2;
		logic             ck_prev;
		logic             cke_prev;
		drt_state_type    st;
		logic [NBANK-1:0] open;
		logic             a12;
		logic [CW-1:0]    burst;
		logic [AW-1:0]    row;
		logic             refp;
		logic             dll;
		logic             bufs;
		logic             pdact;
		logic [15:0]      srtim;
	} drt_mem_st_type;

	drt_mem_st_type s_q;
	drt_mem_st_type s_d;
	drt_pin_type    p;
	logic           rise;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.s1 = '{lk.ck, lk.cke, {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n},
			lk.odt, lk.ba, lk.addr};
		s_d.s2 = s_q.s1;
		s_d.ck_prev = s_q.s2.ck;
		s_d.refp = 1'b0;
		p = s_q.s2;
		rise = p.ck && !s_q.ck_prev;
		// (R13) Timed self refresh
		if (s_q.st == ST_SR) begin
			if (s_q.srtim == 16'(SREF_CYC - 1)) begin
				s_d.srtim = '0;
				s_d.refp = 1'b1;
				s_d.row = s_q.row + 1'b1;
			end else begin
				s_d.srtim = s_q.srtim + 1'b1;
			end
		end
		if (rise) begin
			s_d.cke_prev = p.cke;
			if (s_q.burst != '0) begin
				s_d.burst = s_q.burst - 1'b1;
			end
			unique case (s_q.st)
				ST_RUN: begin
					if (s_q.cke_prev && p.cke) begin
						unique case (p.cmd)
							// (R6) Refresh from counter
							CMD_REF: begin
								s_d.row = s_q.row + 1'b1;
								s_d.refp = 1'b1;
								// (R8) All banks idle
								s_d.open = '0;
							end
							CMD_MRS: begin
								if (p.ba == '0) begin
									s_d.a12 = p.addr[A12_BIT];
								end
							end
							CMD_ACT: s_d.open[p.ba] = 1'b1;
							CMD_PRE: begin
								if (p.addr[A10_BIT]) begin
									s_d.open = '0;
								end else begin
									s_d.open[p.ba] = 1'b0;
								end
							end
							CMD_RD, CMD_WR: begin
								s_d.burst = CW'(BL2);
								if (p.addr[A10_BIT]) begin
									s_d.open[p.ba] = 1'b0;
								end
							end
							// (R23) NOP keeps burst running
							default: s_d.burst = s_d.burst;
						endcase
					end else if (s_q.cke_prev) begin
						if (p.cmd == CMD_REF) begin
							// (R10) Self refresh entry
							s_d.st = ST_SR;
							// (R12) DLL off
							s_d.dll = 1'b0;
							s_d.bufs = 1'b0;
							s_d.refp = 1'b1;
							s_d.row = s_q.row + 1'b1;
							s_d.srtim = '0;
						end else if (p.cmd[3] || p.cmd == CMD_NOP) begin
							// (R18) Power-down entry
							s_d.st = ST_PD;
							// (R19) Precharge or active kind
							s_d.pdact = s_q.open != '0;
							s_d.dll = s_q.open != '0 && !s_q.a12;
							// (R20) Buffers off
							s_d.bufs = 1'b0;
						end
					end
				end
				ST_SR, ST_PD: begin
					// (R12) Exit restores DLL
					// (R21) Exit on CKE high
					if (p.cke) begin
						s_d.st = ST_RUN;
						s_d.dll = 1'b1;
						s_d.bufs = 1'b1;
						s_d.pdact = 1'b0;
					end
				end
				default: s_d.st = ST_RUN;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.st <= ST_RUN;
			s_q.dll <= 1'b1;
			s_q.bufs <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign ref_row    = s_q.row;
	assign ref_pulse  = s_q.refp;
	assign sref_on    = s_q.st == ST_SR;
	assign pd_on      = s_q.st == ST_PD;
	assign pd_active  = s_q.pdact;
	assign dll_en     = s_q.dll;
	assign inbuf_en   = s_q.bufs;
	assign burst_busy = s_q.burst != '0;
	assign open_banks = s_q.open;

endmodule

// ---- drt_ctl.sv ----
// Purpose: Controller end: issues commands, refresh and low-power moves
// Assumes: Software posts one command at a time over APB
// Notes:   CK is pclk divided; pins change on CK falling edges
// How it works
// (R1) Other-bank commands allowed during auto-precharge; ACT to any bank here still waits for G_RP after one
// (R2) Spacing after write with auto-precharge
// (R3) Spacing after read with auto-precharge
// (R4) No precharge-all during concurrent auto-precharge
// (R5) Refresh every row within 64 ms
// (R6) Device refreshes rows from internal counter
// (R7) All banks precharged tRP before refresh
// (R8) Wait tRFC after refresh
// (R9) Refresh every tREFI, at most eight postponed
// (R10) Self refresh only with all banks idle
// (R11) ODT off before self refresh entry
// (R12) CKE held low during self refresh
// (R13) Stay in self refresh at least tCKE
// (R14) Clock stable before self refresh exit
// (R15) Only NOPs for tXSNR after exit
// (R16) No read for tXSRD, ODT off
// (R17) Extra refresh before re-entering self refresh
// (R18) No CKE low during reads, writes, MRS; only power-down entry waits for G_PD here, self refresh entry does not
// (R19) Device picks power-down kind and exit speed
// (R20) Power-down bounded by nine tREFI
// (R21) Wait exit latency after power-down exit
// (R22) Power-down entry spacing after read/write
// (R23) NOP does not end bursts
// (R24) Count postponed refreshes, force at limit
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module drt_ctl import drt_pkg::*; (
	input  wire logic        pclk,     // System clock
	input  wire logic        presetn,  // Async reset, active low
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB access phase
	input  wire logic        pwrite,   // APB write
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error on unmapped address
	drt_link_if.ctl          lk        // Link to device
);

	localparam int G_RD   = 0;
	localparam int G_WR   = 1;
	localparam int G_PA   = 2;
	localparam int G_PD   = 3;
	localparam int G_AP   = 4;
	localparam int G_RP   = 5;
	localparam int G_RFC  = 6;
	localparam int G_X    = 7;
	localparam int G_XSRD = 8;
	localparam int G_CKE  = 9;
	localparam int NG     = 10;

	typedef struct packed {
		logic [DIV_W-1:0]     div;
		logic                 ck;
		logic                 cke;
		logic [3:0]           pins;
		logic                 odt;
		logic [BW-1:0]        ba;
		logic [AW-1:0]        addr;
		drt_state_type        st;
		logic [NBANK-1:0]     open;
		logic                 a12;
		logic                 pdact;
		logic                 auto_en;
		logic                 odt_req;
		logic                 pend;
		logic [3:0]           op;
		logic [BW-1:0]        bank;
		logic                 ap;
		logic [AW-1:0]        row;
		logic [3:0]           post;
		logic                 need_ref;
		logic [CW-1:0]        refi;
		logic [NG-1:0][CW-1:0] g;
		logic [31:0]          rdata;
	} drt_ctl_st_type;

	drt_ctl_st_type s_q;
	drt_ctl_st_type s_d;
	drt_op_type     op;
	logic           ok;
	logic           tick;
	logic           force_ref;

	function automatic logic mapped(input logic [7:0] a);
		return a == REG_CTRL || a == REG_CMD || a == REG_STAT;
	endfunction

	function automatic logic [CW-1:0] ld(input logic [CW-1:0] cur,
		input int v);
		return (cur > CW'(v)) ? cur : CW'(v);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		op = OP_NOP;
		ok = 1'b0;
		force_ref = s_q.post == 4'(MAX_POST);
		// (R14) Free-running CK, never stopped
		tick = s_q.div == DIV_W'(CK_HALF - 1);
		s_d.div = tick ? '0 : s_q.div + 1'b1;
		if (tick) begin
			s_d.ck = ~s_q.ck;
		end

		// APB: read data latched in setup phase
		if (psel && !penable) begin
			s_d.rdata = '0;
			if (paddr == REG_CTRL) begin
				s_d.rdata[CTRL_AUTO] = s_q.auto_en;
				s_d.rdata[CTRL_ODT] = s_q.odt_req;
			end else if (paddr == REG_CMD) begin
				s_d.rdata[CMDF_OP +: 4] = s_q.op;
				s_d.rdata[CMDF_BANK +: BW] = s_q.bank;
				s_d.rdata[CMDF_AP] = s_q.ap;
				s_d.rdata[CMDF_ADDR +: AW] = s_q.row;
			end else if (paddr == REG_STAT) begin
				s_d.rdata[STF_PEND] = s_q.pend;
				s_d.rdata[STF_STATE +: 2] = s_q.st;
				s_d.rdata[STF_OPEN +: NBANK] = s_q.open;
				s_d.rdata[STF_NEED] = s_q.need_ref;
				s_d.rdata[STF_POST +: 4] = s_q.post;
				s_d.rdata[STF_XSRD] = s_q.g[G_XSRD] != '0;
			end
		end
		if (psel && penable && pwrite) begin
			if (paddr == REG_CTRL) begin
				s_d.auto_en = pwdata[CTRL_AUTO];
				s_d.odt_req = pwdata[CTRL_ODT];
			end else if (paddr == REG_CMD && !s_q.pend) begin
				s_d.pend = 1'b1;
				s_d.op = pwdata[CMDF_OP +: 4];
				s_d.bank = pwdata[CMDF_BANK +: BW];
				s_d.ap = pwdata[CMDF_AP];
				s_d.row = pwdata[CMDF_ADDR +: AW];
			end
		end

		// CK rising edge: device samples, spacing counters advance
		if (tick && !s_q.ck) begin
			for (int i = 0; i < NG; i++) begin
				if (s_q.g[i] != '0) begin
					s_d.g[i] = s_q.g[i] - 1'b1;
				end
			end
			// (R9) Count tREFI periods owed
			if (s_q.st != ST_SR) begin
				if (s_q.refi == CW'(TREFI_CK - 1)) begin
					s_d.refi = '0;
					if (!force_ref) begin
						s_d.post = s_q.post + 1'b1;
					end
				end else begin
					s_d.refi = s_q.refi + 1'b1;
				end
			end
		end

		// CK falling edge: choose and drive the next command
		if (tick && s_q.ck) begin
			s_d.pins = CMD_NOP;
			// (R16) ODT off during tXSRD
			s_d.odt = s_q.odt_req && s_q.g[G_XSRD] == '0
				&& s_q.st == ST_RUN
				&& !(s_q.pend && s_q.op == OP_SRE);
			unique case (s_q.st)
				ST_RUN: begin
					// (R15) Only NOP until exit latency met
					if (s_q.g[G_X] == '0) begin
						// (R24) Forced or idle-time refresh
						if (force_ref || (s_q.auto_en && s_q.post != '0
							&& !s_q.pend)) begin
							op = (s_q.open != '0) ? OP_PREA : OP_REF;
						end else if (s_q.pend) begin
							op = drt_op_type'(s_q.op);
						end
					end
				end
				ST_PD: begin
					// (R20) Leave power-down at refresh limit
					if (force_ref || (s_q.pend && s_q.op == OP_PDX)) begin
						op = OP_PDX;
					end
				end
				ST_SR: begin
					if (s_q.pend && s_q.op == OP_SRX) begin
						op = OP_SRX;
					end
				end
				default: op = OP_NOP;
			endcase

			unique case (op)
				OP_ACT: begin
					ok = s_q.g[G_PA] == '0 && s_q.g[G_RFC] == '0
						&& s_q.g[G_RP] == '0 && !s_q.open[s_q.bank];
					if (ok) begin
						s_d.pins = CMD_ACT;
						s_d.open[s_q.bank] = 1'b1;
						s_d.g[G_RD] = ld(s_q.g[G_RD], TRCD_CK);
						s_d.g[G_WR] = ld(s_q.g[G_WR], TRCD_CK);
						s_d.g[G_PD] = ld(s_q.g[G_PD], 1);
					end
				end
				OP_RD: begin
					// (R16) Reads wait for tXSRD
					ok = s_q.g[G_RD] == '0 && s_q.g[G_XSRD] == '0
						&& s_q.open[s_q.bank];
					if (ok) begin
						s_d.pins = CMD_RD;
						// (R3) Read spacing
						s_d.g[G_RD] = ld(s_q.g[G_RD], RDA_RD);
						s_d.g[G_WR] = ld(s_q.g[G_WR], RDA_WR);
						s_d.g[G_PA] = ld(s_q.g[G_PA], RDA_PA);
						// (R22) Power-down after read
						s_d.g[G_PD] = ld(s_q.g[G_PD], RD_PD);
						if (s_q.ap) begin
							s_d.open[s_q.bank] = 1'b0;
							s_d.g[G_AP] = ld(s_q.g[G_AP], RD_PD);
							s_d.g[G_RP] = ld(s_q.g[G_RP], RD_PD + TRP_CK);
						end
					end
				end
				OP_WR: begin
					ok = s_q.g[G_WR] == '0 && s_q.open[s_q.bank];
					if (ok) begin
						s_d.pins = CMD_WR;
						// (R2) Write spacing
						s_d.g[G_RD] = ld(s_q.g[G_RD], WRA_RD);
						s_d.g[G_WR] = ld(s_q.g[G_WR], WRA_WR);
						s_d.g[G_PA] = ld(s_q.g[G_PA],
							s_q.ap ? WRA_RD : WRA_PD);
						// (R22) Power-down after write
						s_d.g[G_PD] = ld(s_q.g[G_PD],
							s_q.ap ? WRA_PD : WR_PD);
						if (s_q.ap) begin
							s_d.open[s_q.bank] = 1'b0;
							s_d.g[G_AP] = ld(s_q.g[G_AP], WRA_PD);
							s_d.g[G_RP] = ld(s_q.g[G_RP], WRA_PD + TRP_CK);
						end
					end
				end
				OP_PRE: begin
					// (R1) Other bank during auto-precharge
					ok = s_q.g[G_PA] == '0;
					if (ok) begin
						s_d.pins = CMD_PRE;
						s_d.open[s_q.bank] = 1'b0;
						s_d.g[G_RP] = ld(s_q.g[G_RP], TRP_CK);
					end
				end
				OP_PREA: begin
					// (R4) Wait out concurrent auto-precharge
					ok = s_q.g[G_PA] == '0 && s_q.g[G_AP] == '0;
					if (ok) begin
						s_d.pins = CMD_PRE;
						s_d.open = '0;
						s_d.g[G_RP] = ld(s_q.g[G_RP], TRP_CK);
					end
				end
				OP_REF, OP_MRS, OP_SRE: begin
					// (R7) Banks idle for tRP
					// (R8) tRFC between refreshes
					// (R10) All banks idle
					ok = s_q.open == '0 && s_q.g[G_RP] == '0
						&& s_q.g[G_RFC] == '0;
					if (op == OP_SRE) begin
						// (R11) ODT low first
						// (R17) Extra refresh owed
						ok = ok && !s_q.odt && !s_q.need_ref;
					end
					if (ok && op == OP_REF) begin
						// (R5) Periodic refresh
						s_d.pins = CMD_REF;
						s_d.g[G_RFC] = ld(s_q.g[G_RFC], TRFC_CK);
						s_d.post = (s_q.post != '0) ? s_q.post - 1'b1 : '0;
						s_d.need_ref = 1'b0;
					end else if (ok && op == OP_MRS) begin
						s_d.pins = CMD_MRS;
						if (s_q.bank == '0) begin
							s_d.a12 = s_q.row[A12_BIT];
						end
						for (int i = G_RD; i <= G_PD; i++) begin
							s_d.g[i] = ld(s_q.g[i], TMRD_CK);
						end
					end else if (ok) begin
						s_d.pins = CMD_REF;
						// (R12) CKE low holds self refresh
						s_d.cke = 1'b0;
						s_d.st = ST_SR;
						s_d.post = '0;
						s_d.refi = '0;
						// (R13) Minimum self refresh time
						s_d.g[G_CKE] = ld(s_q.g[G_CKE], TCKE_CK);
					end
				end
				OP_SRX: begin
					ok = s_q.st != ST_SR || s_q.g[G_CKE] == '0;
					if (ok && s_q.st == ST_SR) begin
						s_d.cke = 1'b1;
						s_d.st = ST_RUN;
						// (R15) tXSNR of NOPs
						s_d.g[G_X] = ld(s_q.g[G_X], TXSNR_CK);
						s_d.g[G_XSRD] = ld(s_q.g[G_XSRD], TXSRD_CK);
						s_d.need_ref = 1'b1;
					end
				end
				OP_PDE: begin
					// (R18) Not during read, write or MRS
					ok = s_q.g[G_PD] == '0;
					if (ok) begin
						s_d.cke = 1'b0;
						s_d.st = ST_PD;
						s_d.pdact = s_q.open != '0;
					end
				end
				OP_PDX: begin
					ok = 1'b1;
					if (s_q.st == ST_PD) begin
						s_d.cke = 1'b1;
						s_d.st = ST_RUN;
						// (R21) Exit latency by mode
						s_d.g[G_X] = ld(s_q.g[G_X],
							(s_q.pdact && s_q.a12) ? TXARDS_CK : TXP_CK);
					end
				end
				default: ok = 1'b1;
			endcase
			if (ok && s_q.pend && op == drt_op_type'(s_q.op)) begin
				s_d.pend = 1'b0;
			end
			s_d.ba = s_q.bank;
			s_d.addr = s_q.row;
			if (op == OP_RD || op == OP_WR || op == OP_PRE) begin
				s_d.addr[A10_BIT] = s_q.ap && op != OP_PRE;
			end else if (op == OP_PREA) begin
				s_d.addr[A10_BIT] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.st <= ST_RUN;
			s_q.cke <= 1'b1;
			s_q.pins <= CMD_NOP;
			s_q.auto_en <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata   = s_q.rdata;
	assign pready   = psel && penable;
	assign pslverr  = psel && penable && !mapped(paddr);
	assign lk.ck    = s_q.ck;
	assign lk.cke   = s_q.cke;
	assign {lk.cs_n, lk.ras_n, lk.cas_n, lk.we_n} = s_q.pins;
	assign lk.odt   = s_q.odt;
	assign lk.ba    = s_q.ba;
	assign lk.addr  = s_q.addr;

endmodule

// ---- drt_link_properties.sv ----
// Purpose: Link timing checks between controller and device ends
// Assumes: Pins change on ck falls; command taken on ck rise
// Notes:   Spacing counters count link clocks since each command
`timescale 1ns/100ps
module drt_link_properties import drt_pkg::*; (
	input wire logic          pclk,    // System clock
	input wire logic          presetn, // Reset, active low
	input wire logic          ck,      // Link clock
	input wire logic          cke,     // Clock enable
	input wire logic          cs_n,    // Chip select
	input wire logic          ras_n,   // Row strobe
	input wire logic          cas_n,   // Column strobe
	input wire logic          we_n,    // Write enable
	input wire logic          odt,     // Termination
	input wire logic [AW-1:0] addr     // Address
);
	logic        ck_q, kq, sr_q;
	logic [15:0] lo_q, xs_q, rf_q, rd_q, wr_q, wa_q;
	wire [3:0]   cmd = {cs_n, ras_n, cas_n, we_n};
	wire         rc  = ck & ~ck_q;
	wire         go  = kq & cke;
	wire         sre = kq & ~cke & (cmd == CMD_REF);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ck_q, kq, sr_q} <= 3'h2;
			{lo_q, rf_q} <= 32'h0;
			{xs_q, rd_q, wr_q, wa_q} <= '1;
		end else begin
			ck_q <= ck;
			lo_q <= cke ? 16'h0 : lo_q + 16'h1;
			if (rc) begin
				kq <= cke;
				sr_q <= sre | (sr_q & ~cke);
				xs_q <= sr_q & cke ? 16'h1 : xs_q + 16'(xs_q != '1);
				rf_q <= (kq & cmd == CMD_REF) | sr_q ? 16'h0 : rf_q + 16'h1;
				rd_q <= go & cmd == CMD_RD ? 16'h1 : rd_q + 16'(rd_q != '1);
				wr_q <= go & cmd == CMD_WR ? 16'h1 : wr_q + 16'(wr_q != '1);
				wa_q <= go & cmd == CMD_WR & addr[A10_BIT] ? 16'h1 :
					wa_q + 16'(wa_q != '1);
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_nop8; (cs_n || cmd == CMD_NOP) [*8]; endsequence

	property p_edge; !$stable({cke, cmd}) |-> $fell(ck); endproperty
	a_edge: assert property (p_edge)
		else $error("pins moved off a ck fall");
	property p_odt; rc && sre |-> !odt; endproperty
	a_odt: assert property (p_odt)
		else $error("odt on at self refresh entry");
	property p_ckl; rc && kq && !cke |->
		cs_n || cmd == CMD_NOP || sre; endproperty
	a_ckl: assert property (p_ckl)
		else $error("bad command with cke fall");
	property p_pdx; rc && !kq && cke |-> cs_n || cmd == CMD_NOP; endproperty
	a_pdx: assert property (p_pdx)
		else $error("bad command with cke rise");
	property p_srmin; $rose(cke) && sr_q |-> lo_q >= TCKE_CK * 8; endproperty
	a_srmin: assert property (p_srmin)
		else $error("self refresh too short");
	property p_srx; $rose(cke) && sr_q |-> s_nop8 ##1 s_nop8; endproperty
	a_srx: assert property (p_srx)
		else $error("command inside exit window");
	property p_xsrd; rc && go && cmd == CMD_RD |-> xs_q >= TXSRD_CK; endproperty
	a_xsrd: assert property (p_xsrd)
		else $error("read too soon after self refresh");
	property p_pde; rc && kq && !cke && !sre |->
		rd_q >= RD_PD && wr_q >= WR_PD && wa_q >= WRA_PD; endproperty
	a_pde: assert property (p_pde)
		else $error("power-down too soon after access");
	property p_wra; rc && go && (cmd == CMD_RD || cmd == CMD_ACT) |->
		wa_q >= WRA_RD; endproperty
	a_wra: assert property (p_wra)
		else $error("command too soon after write with precharge");
	property p_gap; rf_q <= 9 * TREFI_CK; endproperty
	a_gap: assert property (p_gap)
		else $error("refresh gap too long");
endmodule

// ---- ddr2_refresh_powerdown_timing_tb_top.sv ----
// Purpose: Drive controller over APB and judge device end state
// Assumes: Zero wait APB; auto refresh on from reset until the end of the first test, then off except last test
// Notes:   Device reacts a few link clocks after a command clears
`timescale 1ns/100ps
module ddr2_refresh_powerdown_timing_tb_top import drt_pkg::*;;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic           er, ref_pulse, sref_on, pd_on, pd_active, dll_en;
	logic           inbuf_en, busy;
	logic [AW-1:0]  ref_row, rw, row_w;
	logic [NBANK-1:0] open_banks;
	int             n_mismatch, comparisons, n_ref, n0, n_busy;

	drt_link_if lk();
	drt_ctl i_drt_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .lk);
	drt_mem i_drt_mem (.pclk, .presetn, .lk, .ref_row, .ref_pulse, .sref_on,
		.pd_on, .pd_active, .dll_en, .inbuf_en, .burst_busy(busy), .open_banks);
	drt_link_properties i_chk (.pclk, .presetn, .ck(lk.ck), .cke(lk.cke),
		.cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n),
		.odt(lk.odt), .addr(lk.addr));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) if (ref_pulse === 1'b1) n_ref++;
	always @(posedge pclk) if (busy === 1'b1) n_busy++;

	task end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task wck(input int n);
		repeat (n * 8) @(posedge pclk);
	endtask
	task cmd(input logic [3:0] op, input logic [1:0] b, input logic ap);
		int i;
		apb(1'b1, REG_CMD, {11'h0, row_w, 1'b0, ap, b, op});
		rd = 32'h1;
		for (i = 0; i < 1000 && rd[0] !== 1'b0; i++) apb(1'b0, REG_STAT, 0);
		chk("pend", 32'(rd[0]), 32'h0);
		wck(3);
	endtask

	task t_regs;
		apb(1'b0, REG_CTRL, 0);
		chk("ctrl", rd, 32'h1);
		apb(1'b0, 8'h0C, 0);
		chk("slverr", 32'(er), 32'h1);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, REG_CTRL, 0);
		wck(4);
	endtask
	task t_ref;
		n0 = n_ref;
		rw = ref_row;
		cmd(4'h6, 2'h0, 1'b0);
		chk("ref_row", 32'(ref_row), 32'(rw + 13'h1));
		chk("ref_cnt", n_ref - n0, 1);
	endtask
	task t_pd;
		cmd(4'h1, 2'h1, 1'b0);
		chk("open", 32'(open_banks), 32'h2);
		cmd(4'hA, 2'h0, 1'b0);
		chk("pd_act", 32'({pd_on, pd_active, inbuf_en}), 32'h6);
		cmd(4'hB, 2'h0, 1'b0);
		chk("pd_off", 32'({pd_on, inbuf_en}), 32'h1);
		n0 = n_busy;
		cmd(4'h2, 2'h1, 1'b1);
		chk("busy", n_busy - n0, BL2 * 2 * CK_HALF);
		cmd(4'hA, 2'h0, 1'b0);
		chk("pd_pre", 32'({pd_on, pd_active, open_banks}), 32'h20);
		cmd(4'hB, 2'h0, 1'b0);
		row_w[A12_BIT] = 1'b1;
		cmd(4'h7, 2'h0, 1'b0);
		row_w = '0;
		cmd(4'h1, 2'h1, 1'b0);
		cmd(4'hA, 2'h0, 1'b0);
		chk("pd_slow", 32'({pd_active, dll_en}), 32'h2);
		cmd(4'hB, 2'h0, 1'b0);
		cmd(4'h4, 2'h1, 1'b0);
	endtask
	task t_wra;
		cmd(4'h1, 2'h0, 1'b0);
		cmd(4'h1, 2'h2, 1'b0);
		cmd(4'h3, 2'h0, 1'b1);
		cmd(4'h2, 2'h2, 1'b0);
		wck(4);
		chk("open_wa", 32'(open_banks), 32'h4);
		cmd(4'h5, 2'h0, 1'b0);
	endtask
	task t_sr;
		apb(1'b1, REG_CTRL, 32'h2);
		wck(3);
		chk("odt_on", 32'(lk.odt), 32'h1);
		n0 = n_ref;
		cmd(4'h8, 2'h0, 1'b0);
		chk("sr_on", 32'({sref_on, dll_en, lk.odt}), 32'h4);
		chk("sr_ref", 32'(n_ref > n0), 32'h1);
		apb(1'b1, REG_CTRL, 0);
		wck(4);
		cmd(4'h9, 2'h0, 1'b0);
		chk("sr_off", 32'({sref_on, dll_en}), 32'h1);
		apb(1'b0, REG_STAT, 0);
		chk("owed", 32'({rd[STF_XSRD], rd[STF_NEED]}), 32'h3);
		cmd(4'h1, 2'h3, 1'b0);
		cmd(4'h2, 2'h3, 1'b0);
		apb(1'b0, REG_STAT, 0);
		chk("xsrd", 32'(rd[STF_XSRD]), 32'h0);
		cmd(4'h5, 2'h0, 1'b0);
		cmd(4'h6, 2'h0, 1'b0);
		apb(1'b0, REG_STAT, 0);
		chk("paid", 32'(rd[STF_NEED]), 32'h0);
	endtask
	task t_auto;
		apb(1'b1, REG_CTRL, 32'h1);
		n0 = n_ref;
		wck(2 * TREFI_CK + 8);
		chk("auto", 32'(n_ref - n0 >= 2), 32'h1);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{n_mismatch, comparisons, n_ref, n_busy} = '0;
		row_w = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_ref;
		t_pd;
		t_wra;
		t_sr;
		t_auto;
		end_of_test;
	end
	initial begin
		#600000;
		n_mismatch++;
		end_of_test;
	end
endmodule
